// File: hw/ss_cap_cfg.svh
`ifndef SS_CAP_CFG_SVH
`define SS_CAP_CFG_SVH

// ----------------------------------------------------------------
// descriptor image
// ----------------------------------------------------------------
`define CAP_LEN 8'h0a
`define CAP_SUBTYPE 8'h03
`define CAP_LAST_IDX 8'h09
`define U1_MAX 8'h0a
`define U2_MAX 16'h07ff
`define ATTR_LTM_BIT 1
`define SPEED_SS_BIT 3

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_SPEED 8'h04
`define OFF_LAT 8'h08
`define OFF_STAT 8'h0c
`define CTRL_LTM_BIT 1
`define SPEED_FUNC_LSB 8
`define LAT_U2_LSB 16
`define STAT_REFUSED_LSB 8
`define STAT_SERVED_LSB 16

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define RST_LTM 1'b0
`define RST_SPEEDS 4'h8
`define RST_FUNC 2'h3
`define RST_U1 8'h0a
`define RST_U2 16'h07ff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: hw/ss_cap_pkg.sv
package ss_cap_pkg;
  typedef enum logic [1:0] {
    REQ_BOS_GET,
    REQ_DIRECT_GET,
    REQ_SET
  } req_kind_e;

  typedef struct packed {
    req_kind_e kind;
    logic [7:0] index;
  } desc_req_s;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic stall;
  } desc_rsp_s;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_HAVE_ADDR,
    WR_HAVE_DATA,
    WR_RESP
  } wr_state_e;
endpackage : ss_cap_pkg

// File: hw/ss_cap_desc.sv
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ss_cap_cfg.svh"
module ss_cap_desc #(
  parameter logic [7:0] DEV_CAP_TYPE = 8'h10
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic desc_req_valid,
  input wire ss_cap_pkg::desc_req_s desc_req,
  output logic desc_rsp_valid,
  output ss_cap_pkg::desc_rsp_s desc_rsp,
  output logic cfg_ok
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic ltm_q;
  logic ltm_d;
  logic [3:0] speeds_q;
  logic [3:0] speeds_d;
  logic [1:0] func_q;
  logic [1:0] func_d;
  logic [7:0] u1_q;
  logic [7:0] u1_d;
  logic [15:0] u2_q;
  logic [15:0] u2_d;
  logic [7:0] refused_q;
  logic [7:0] refused_d;
  logic [7:0] served_q;
  logic [7:0] served_d;

  // write channel
  ss_cap_pkg::wr_state_e wr_q;
  ss_cap_pkg::wr_state_e wr_d;
  logic [7:0] waddr_q;
  logic [7:0] waddr_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [3:0] wstrb_q;
  logic [3:0] wstrb_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;

  // read channel
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;

  // descriptor answer
  logic rsp_valid_q;
  logic rsp_valid_d;
  ss_cap_pkg::desc_rsp_s rsp_q;
  ss_cap_pkg::desc_rsp_s rsp_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // bit 32 flags a mapped address
  function automatic logic [32:0] reg_word(input logic [7:0] addr);
    logic [32:0] w;
    w = 33'h0;
    if (addr == `OFF_CTRL)
    begin
      w[32] = 1'b1;
      w[`CTRL_LTM_BIT] = ltm_q;
    end
    else if (addr == `OFF_SPEED)
    begin
      w[32] = 1'b1;
      w[3:0] = speeds_q;
      w[`SPEED_FUNC_LSB +: 2] = func_q;
    end
    else if (addr == `OFF_LAT)
    begin
      w[32] = 1'b1;
      w[7:0] = u1_q;
      w[`LAT_U2_LSB +: 16] = u2_q;
    end
    else if (addr == `OFF_STAT)
    begin
      w[32] = 1'b1;
      w[0] = cfg_ok;
      w[`STAT_REFUSED_LSB +: 8] = refused_q;
      w[`STAT_SERVED_LSB +: 8] = served_q;
    end
    return w;
  endfunction : reg_word

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // image is built live from the registers, low byte first
  function automatic logic [7:0] desc_byte(input logic [7:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      8'h00: b = `CAP_LEN;
      8'h01: b = DEV_CAP_TYPE;
      8'h02: b = `CAP_SUBTYPE;
      8'h03: b[`ATTR_LTM_BIT] = ltm_q;
      8'h04: b[3:0] = speeds_q;
      8'h05: b = 8'h00;
      8'h06: b = {6'h00, func_q};
      8'h07: b = u1_q;
      8'h08: b = u2_q[7:0];
      8'h09: b = u2_q[15:8];
      default: b = 8'h00;
    endcase
    return b;
  endfunction : desc_byte

  // function support must name a supported speed, and 5 gbps is a must
  assign cfg_ok = speeds_q[`SPEED_SS_BIT] && speeds_q[func_q];

  // ----------------------------------------------------------------
  // axi4-lite write
  // ----------------------------------------------------------------
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [32:0] wr_old;
  logic [31:0] wr_new;

  always_comb
  begin
    wr_d = wr_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bresp_d = bresp_q;
    wr_fire = 1'b0;
    wr_addr = s_axi_awaddr;
    wr_data = s_axi_wdata;
    wr_strb = s_axi_wstrb;
    s_axi_awready = 1'b0;
    s_axi_wready = 1'b0;
    case (wr_q)
      ss_cap_pkg::WR_IDLE:
      begin
        s_axi_awready = ce;
        s_axi_wready = ce;
        if (s_axi_awvalid && s_axi_wvalid)
        begin
          wr_fire = 1'b1;
          wr_d = ss_cap_pkg::WR_RESP;
        end
        else if (s_axi_awvalid)
        begin
          waddr_d = s_axi_awaddr;
          wr_d = ss_cap_pkg::WR_HAVE_ADDR;
        end
        else if (s_axi_wvalid)
        begin
          wdata_d = s_axi_wdata;
          wstrb_d = s_axi_wstrb;
          wr_d = ss_cap_pkg::WR_HAVE_DATA;
        end
      end
      ss_cap_pkg::WR_HAVE_ADDR:
      begin
        s_axi_wready = ce;
        wr_addr = waddr_q;
        if (s_axi_wvalid)
        begin
          wr_fire = 1'b1;
          wr_d = ss_cap_pkg::WR_RESP;
        end
      end
      ss_cap_pkg::WR_HAVE_DATA:
      begin
        s_axi_awready = ce;
        wr_data = wdata_q;
        wr_strb = wstrb_q;
        if (s_axi_awvalid)
        begin
          wr_fire = 1'b1;
          wr_d = ss_cap_pkg::WR_RESP;
        end
      end
      default:
      begin
        if (s_axi_bready)
        begin
          wr_d = ss_cap_pkg::WR_IDLE;
        end
      end
    endcase
    wr_old = reg_word(wr_addr);
    wr_new = merge(wr_old[31:0], wr_data, wr_strb);
    if (wr_fire)
    begin
      bresp_d = wr_old[32] ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  assign s_axi_bvalid = (wr_q == ss_cap_pkg::WR_RESP);
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  // out-of-range latencies clamp to the top legal code so a careless
  // write can never place a reserved value in the image
  always_comb
  begin
    ltm_d = ltm_q;
    speeds_d = speeds_q;
    func_d = func_q;
    u1_d = u1_q;
    u2_d = u2_q;
    if (wr_fire && (wr_addr == `OFF_CTRL))
    begin
      ltm_d = wr_new[`CTRL_LTM_BIT];
    end
    else if (wr_fire && (wr_addr == `OFF_SPEED))
    begin
      speeds_d = wr_new[3:0];
      // indices above 3 name no speed; keep the old one
      if (wr_new[`SPEED_FUNC_LSB +: 8] <= 8'h03)
      begin
        func_d = wr_new[`SPEED_FUNC_LSB +: 2];
      end
    end
    else if (wr_fire && (wr_addr == `OFF_LAT))
    begin
      u1_d = (wr_new[7:0] > `U1_MAX) ? `U1_MAX : wr_new[7:0];
      if (wr_new[`LAT_U2_LSB +: 16] > `U2_MAX)
      begin
        u2_d = `U2_MAX;
      end
      else
      begin
        u2_d = wr_new[`LAT_U2_LSB +: 16];
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read
  // ----------------------------------------------------------------
  logic [32:0] rd_word;

  assign s_axi_arready = ce && !rvalid_q;

  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    rd_word = reg_word(s_axi_araddr);
    if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
    else if (!rvalid_q && s_axi_arvalid)
    begin
      rvalid_d = 1'b1;
      rdata_d = rd_word[31:0];
      rresp_d = rd_word[32] ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------------------------------
  // descriptor byte port
  // ----------------------------------------------------------------
  // one byte per request, answered one cycle later; the control
  // engine walks index 0..9 at its place inside the capability set
  always_comb
  begin
    rsp_valid_d = 1'b0;
    rsp_d = rsp_q;
    refused_d = refused_q;
    served_d = served_q;
    if (desc_req_valid)
    begin
      rsp_valid_d = 1'b1;
      rsp_d.data = 8'h00;
      rsp_d.last = 1'b0;
      rsp_d.stall = 1'b0;
      if (desc_req.kind == ss_cap_pkg::REQ_BOS_GET)
      begin
        // always present in the set, only reachable through it
        rsp_d.data = desc_byte(desc_req.index);
        rsp_d.last = (desc_req.index == `CAP_LAST_IDX);
        rsp_d.stall = (desc_req.index > `CAP_LAST_IDX);
        if (desc_req.index <= `CAP_LAST_IDX)
        begin
          served_d = served_q + 8'h01;
        end
      end
      else
      begin
        // direct get and any set are answered with a stall
        rsp_d.stall = 1'b1;
        if (refused_q != 8'hff)
        begin
          refused_d = refused_q + 8'h01;
        end
      end
    end
  end

  assign desc_rsp_valid = rsp_valid_q;
  assign desc_rsp = rsp_q;

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ltm_q <= `RST_LTM;
      speeds_q <= `RST_SPEEDS;
      func_q <= `RST_FUNC;
      u1_q <= `RST_U1;
      u2_q <= `RST_U2;
      refused_q <= 8'h00;
      served_q <= 8'h00;
      wr_q <= ss_cap_pkg::WR_IDLE;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bresp_q <= `RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `RESP_OKAY;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
    end
    else if (ce)
    begin
      ltm_q <= ltm_d;
      speeds_q <= speeds_d;
      func_q <= func_d;
      u1_q <= u1_d;
      u2_q <= u2_d;
      refused_q <= refused_d;
      served_q <= served_d;
      wr_q <= wr_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
    end
  end

endmodule : ss_cap_desc

// File: dv/ss_cap_checker.sv
`timescale 1ns/1ps
`include "ss_cap_cfg.svh"
module ss_cap_checker #(
  parameter logic [7:0] DEV_CAP_TYPE = 8'h10
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic desc_req_valid,
  input wire ss_cap_pkg::desc_req_s desc_req,
  input wire logic desc_rsp_valid,
  input wire ss_cap_pkg::desc_rsp_s desc_rsp,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp
);
  // ---------------------------------------------
  // descriptor port properties, plus a write-response cover
  // ---------------------------------------------
  logic bos;
  logic bad;
  logic [7:0] ix;
  logic [7:0] d;
  assign ix = desc_req.index;
  assign d = desc_rsp.data;
  assign bos = desc_req_valid && ce &&
    desc_req.kind == ss_cap_pkg::REQ_BOS_GET;
  assign bad = desc_req_valid && ce && !bos;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  a_rsp_next: assert property (desc_req_valid && ce |=> desc_rsp_valid)
    else $error("late answer");
  a_rsp_pulse: assert property (ce && !desc_req_valid |=> !desc_rsp_valid)
    else $error("spurious answer");
  a_refuse_stall: assert property (bad |=> desc_rsp.stall && d == 8'h00)
    else $error("refused request served");
  a_size_byte: assert property (bos && ix == 8'h00 |=> d == `CAP_LEN)
    else $error("bad size byte");
  a_type_byte: assert property (bos && ix == 8'h01 |=> d == DEV_CAP_TYPE)
    else $error("bad type byte");
  a_subtype_byte: assert property (bos && ix == 8'h02 |=> d == 8'h03)
    else $error("bad subtype byte");
  a_attr_bits: assert property (bos && ix == 8'h03 |=> (d & 8'hfd) == 8'h00)
    else $error("reserved attribute bit set");
  a_speed_high: assert property (bos && ix == 8'h05 |=> d == 8'h00)
    else $error("reserved speed bit set");
  a_u1_range: assert property (bos && ix == 8'h07 |=> d <= 8'h0a)
    else $error("u1 latency reserved");
  a_u2_range: assert property (bos && ix == 8'h09 |=> d <= 8'h07)
    else $error("u2 latency reserved");
  a_last_flag: assert property (bos |=>
    desc_rsp.last == ($past(desc_req.index) == 8'h09))
    else $error("bad last flag");
  c_last: cover property (bos && ix == 8'h09);
  c_refused: cover property (bad);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule : ss_cap_checker

bind ss_cap_desc ss_cap_checker #(.DEV_CAP_TYPE(DEV_CAP_TYPE)) i_chk (
  .clock, .rstn, .ce, .desc_req_valid, .desc_req, .desc_rsp_valid,
  .desc_rsp, .s_axi_bvalid, .s_axi_bresp);

// File: dv/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic start,
  input wire ss_cap_pkg::req_kind_e kind,
  output logic req_valid,
  output ss_cap_pkg::desc_req_s req,
  input wire logic rsp_valid,
  input wire ss_cap_pkg::desc_rsp_s rsp,
  output logic [87:0] got,
  output logic [10:0] stl,
  output logic [10:0] lst,
  output logic done
);
  // ---------------------------------------------
  // whole-set sweep, one past the end
  // ---------------------------------------------
  logic [3:0] n;
  logic [3:0] r;
  assign req_valid = n < 4'hb;
  assign req.kind = kind;
  assign req.index = {4'h0, n};
  assign done = n == 4'hb && r == 4'hb;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      n <= 4'hb;
    else if (start)
      n <= 4'h0;
    else if (req_valid)
      n <= n + 4'h1;
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      r <= 4'hb;
    else if (start)
      r <= 4'h0;
    else if (rsp_valid)
    begin
      got[{r, 3'b000} +: 8] <= rsp.data;
      stl[r] <= rsp.stall;
      lst[r] <= rsp.last;
      r <= r + 4'h1;
    end
  end
endmodule : host_model

// File: dv/ss_cap_desc_bench.sv
`timescale 1ns/1ps
module ss_cap_desc_bench;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] speed;
    logic [31:0] lat;
    ss_cap_pkg::req_kind_e kind;
    logic [87:0] img;
  } row_s;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic start = 1'b0;
  ss_cap_pkg::req_kind_e kind = ss_cap_pkg::REQ_BOS_GET;
  logic awready, wready, bvalid, arready, rvalid, cfg_ok;
  logic req_valid, rsp_valid, done;
  logic [1:0] bresp, rresp, rp;
  logic [31:0] rdata, q;
  ss_cap_pkg::desc_req_s req;
  ss_cap_pkg::desc_rsp_s rsp;
  logic [87:0] got;
  logic [10:0] stl, lst;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  row_s rows [0:3];
  logic [31:0] rv [0:4];
  always #4 clock = ~clock;
  ss_cap_desc i_dut (
    .clock(clock), .rstn(rstn), .ce(ce),
    .s_axi_awaddr(addr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(addr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .desc_req_valid(req_valid), .desc_req(req),
    .desc_rsp_valid(rsp_valid), .desc_rsp(rsp), .cfg_ok(cfg_ok));
  host_model i_host (.clock, .rstn, .start, .kind, .req_valid, .req,
    .rsp_valid, .rsp, .got, .stl, .lst, .done);
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic chk(input logic [87:0] seen, input logic [87:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // ready is looked at on the falling edge so no race with the rising one
  task automatic axi(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [1:0] erp);
    int t;
    logic ah, wh, rh, fin;
    t = 0;
    fin = 1'b0;
    addr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    arvalid <= !wr;
    while (!fin && t < 40)
    begin
      @(negedge clock);
      ah = awready && awvalid;
      wh = wready && wvalid;
      rh = arready && arvalid;
      fin = wr ? bvalid : rvalid;
      q = rdata;
      rp = wr ? bresp : rresp;
      @(posedge clock);
      // a finished call leaves its strobes alone so the next call owns them
      if (!fin)
      begin
        awvalid <= awvalid && !ah;
        wvalid <= wvalid && !wh;
        arvalid <= arvalid && !rh;
      end
      t++;
    end
    if (!fin)
      bad_count++;
    chk(rp, erp);
  endtask : axi
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      finish_test;
    end
  end
  // ---------------------------------------------
  // sequence
  // ---------------------------------------------
  initial
  begin
    rows[0] = '{32'h2, 32'h10f, 32'h080000ff, ss_cap_pkg::REQ_BOS_GET,
      88'h00_07_ff_0a_01_00_0f_02_03_10_0a};
    rows[1] = '{32'hfffffffd, 32'hfff004f4, 32'h00010000,
      ss_cap_pkg::REQ_BOS_GET, 88'h00_00_01_00_01_00_04_00_03_10_0a};
    rows[2] = '{32'h0, 32'h0, 32'h0, ss_cap_pkg::REQ_DIRECT_GET, 88'h0};
    rows[3] = '{32'h0, 32'h0, 32'h0, ss_cap_pkg::REQ_SET, 88'h0};
    rv = '{32'h0, 32'h308, 32'h07ff000a, 32'h1, 32'h0};
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    chk(cfg_ok, 1'b1);
    foreach (rows[i])
    begin
      axi(1'b1, 8'h00, rows[i].ctrl, 2'h0);
      axi(1'b1, 8'h04, rows[i].speed, 2'h0);
      axi(1'b1, 8'h08, rows[i].lat, 2'h0);
      chk(cfg_ok, i == 0);
      kind <= rows[i].kind;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      // done still shows the previous sweep until the sweep restarts
      @(negedge clock);
      for (int t = 0; t < 40 && !(done === 1'b1); t++)
        @(negedge clock);
      chk(got, rows[i].img);
      chk(stl, rows[i].kind == 0 ? 11'h400 : 11'h7ff);
      chk(lst[9], rows[i].kind == 0);
      @(posedge clock);
    end
    ce <= 1'b0;
    @(negedge clock);
    chk({awready, wready, arready}, 3'h0);
    @(posedge clock);
    ce <= 1'b1;
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      axi(1'b0, 8'(i * 4), 32'h0, i == 4 ? 2'h2 : 2'h0);
      chk(q, rv[i]);
    end
    axi(1'b1, 8'h0c, 32'h0, 2'h0);
    axi(1'b1, 8'h20, 32'hffffffff, 2'h2);
    axi(1'b0, 8'h0c, 32'h0, 2'h0);
    chk(q, 32'h1);
    finish_test;
  end
endmodule : ss_cap_desc_bench
